/* include/spi_master_pkg.sv */
package spi_master_pkg;

    // register offsets (byte addresses)
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_DIVIDER = 8'h04;
    localparam logic [7:0] OFS_TXDATA = 8'h08;
    localparam logic [7:0] OFS_RXDATA = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;

    // control field positions
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_FOUR_WIRE_BIT = 1;
    localparam int CTRL_RX_DIR_BIT = 2;
    localparam int CTRL_MODE_LSB = 4;
    localparam int CTRL_LEN_LSB = 8;

    // status field positions
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
    localparam int STAT_REFUSED_BIT = 2;

    // clock rates
    localparam longint CLK_HZ = 125_000_000;
    localparam longint SCK_MAX_BPS = 13_000_000;
    localparam longint SCK_MIN_BPS = 101_500;
    // half period of the serial clock in system cycles
    localparam int HALF_MIN = int'((CLK_HZ + 2 * SCK_MAX_BPS - 1) / (2 * SCK_MAX_BPS));
    localparam int HALF_MAX = int'(CLK_HZ / (2 * SCK_MIN_BPS));
    localparam logic [15:0] DIVIDER_RESET = 16'(HALF_MAX);

    localparam logic [31:0] RDATA_UNMAPPED = 32'h0000_0000;

    typedef struct packed {
        logic [3:0] len_m1;
        logic [1:0] mode;
        logic rx_dir;
        logic four_wire;
        logic enable;
    } ctrl_s;

    localparam ctrl_s CTRL_RESET = '{len_m1: 4'h0, mode: 2'h0, rx_dir: 1'b0,
        four_wire: 1'b0, enable: 1'b0};

    typedef struct packed {
        logic clk_o;
        logic clk_oe;
        logic data_o;
        logic data_oe;
        logic sel_n_o;
        logic sel_oe;
    } pins_s;

    localparam pins_s PINS_RESET = '{clk_o: 1'b0, clk_oe: 1'b0, data_o: 1'b0,
        data_oe: 1'b0, sel_n_o: 1'b1, sel_oe: 1'b0};

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_LEAD,
        ST_SHIFT,
        ST_TRAIL
    } xfer_state_e;

endpackage

/* rtl/half_period_divider.sv */
`timescale 1ns/10ps
module half_period_divider import spi_master_pkg::*; #(
    parameter int WIDTH = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // control
    input wire logic run,
    input wire logic [WIDTH-1:0] half,
    // one-cycle enable per serial clock half period
    output logic tick
);

    logic [WIDTH-1:0] count;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            count <= '0;
            tick <= 1'b0;
        end else if (!run) begin
            count <= '0;
            tick <= 1'b0;
        end else if (count == half - WIDTH'(1)) begin
            count <= '0;
            tick <= 1'b1;
        end else begin
            count <= count + WIDTH'(1);
            tick <= 1'b0;
        end
    end

endmodule

/* rtl/serial_peripheral_master.sv */
// Contract
// - master only; serial clock rate programmable between 101.5 kbit/s and 13 Mbit/s
// - any of clock modes zero to three selectable per transfer
// - word length configurable from one to sixteen bits
// - software chooses three-line or four-line data wiring
// - four-line: drive shared line only, sample dedicated input only
// - three-line: shared line driven when sending, released and sampled when receiving
// - slave select driven active for the whole transfer
`timescale 1ns/10ps
module serial_peripheral_master import spi_master_pkg::*; #(
    parameter int DATA_W = 16,
    parameter int DIV_W = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    // serial clock pin
    output logic serial_clock_out,
    output logic serial_clock_oe,
    // shared data pin, two-way
    input wire logic shared_data_line_i,
    output logic shared_data_line_o,
    output logic shared_data_line_oe,
    // dedicated data input pin
    input wire logic dedicated_data_in,
    // slave select pin, active low
    output logic slave_select_out_n,
    output logic slave_select_oe
);

    function automatic logic [DIV_W-1:0] clamp_half(input logic [31:0] v);
        if (v < 32'(HALF_MIN)) begin
            return DIV_W'(HALF_MIN);
        end else if (v > 32'(HALF_MAX)) begin
            return DIV_W'(HALF_MAX);
        end else begin
            return v[DIV_W-1:0];
        end
    endfunction

    ctrl_s ctrl;
    ctrl_s cfg;
    pins_s pins;
    xfer_state_e state;
    logic [DIV_W-1:0] half;
    logic [DATA_W-1:0] tx_word;
    logic [DATA_W-1:0] tx_sh;
    logic [DATA_W-1:0] rx_sh;
    logic [DATA_W-1:0] rx_word;
    logic [4:0] edge_cnt;
    logic done;
    logic refused;
    logic tick;
    logic start;
    logic busy;
    logic in_bit;
    logic sample_edge;
    logic last_edge;
    logic cpol;
    logic cpha;

    assign busy = (state != ST_IDLE);
    assign start = wr && (addr == OFS_TXDATA) && !busy && ctrl.enable;
    assign cpol = cfg.mode[1];
    assign cpha = cfg.mode[0];
    assign sample_edge = (edge_cnt[0] == cpha);
    // second edge of the last bit, the final edge of the word
    assign last_edge = (edge_cnt == {cfg.len_m1, 1'b1});
    // four-line samples the dedicated input, three-line the shared line
    assign in_bit = cfg.four_wire ? dedicated_data_in : shared_data_line_i;

    half_period_divider #(
        .WIDTH(DIV_W)
    ) u_div (
        .clk(clk),
        .rst_b(rst_b),
        .run(busy),
        .half(half),
        .tick(tick)
    );

    // control and divider registers
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ctrl <= CTRL_RESET;
            half <= DIVIDER_RESET;
        end else if (wr && addr == OFS_CTRL) begin
            ctrl.enable <= wdata[CTRL_ENABLE_BIT];
            ctrl.four_wire <= wdata[CTRL_FOUR_WIRE_BIT];
            ctrl.rx_dir <= wdata[CTRL_RX_DIR_BIT];
            ctrl.mode <= wdata[CTRL_MODE_LSB +: 2];
            ctrl.len_m1 <= wdata[CTRL_LEN_LSB +: 4];
        end else if (wr && addr == OFS_DIVIDER) begin
            // clamp keeps the rate inside the legal band
            half <= clamp_half(wdata);
        end
    end

    // transfer engine; config is snapshot so a control write mid-word is harmless
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state <= ST_IDLE;
            cfg <= CTRL_RESET;
            tx_word <= '0;
            tx_sh <= '0;
            rx_sh <= '0;
            rx_word <= '0;
            edge_cnt <= '0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (start) begin
                        cfg <= ctrl;
                        tx_word <= wdata[DATA_W-1:0];
                        // left align so the top bit goes first at any length
                        tx_sh <= wdata[DATA_W-1:0] << (4'hf - ctrl.len_m1);
                        rx_sh <= '0;
                        edge_cnt <= '0;
                        state <= ST_LEAD;
                    end
                end
                ST_LEAD: begin
                    if (tick) begin
                        state <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (tick) begin
                        // sample on first or second edge per phase bit
                        if (sample_edge) begin
                            rx_sh <= {rx_sh[DATA_W-2:0], in_bit};
                        end else if (!(cpha && edge_cnt == 5'h00)) begin
                            tx_sh <= {tx_sh[DATA_W-2:0], 1'b0};
                        end
                        edge_cnt <= edge_cnt + 5'h01;
                        if (last_edge) begin
                            state <= ST_TRAIL;
                        end
                    end
                end
                ST_TRAIL: begin
                    if (tick) begin
                        rx_word <= rx_sh;
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // pin drivers, all from flops; released while disabled and idle, or in reset
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pins <= PINS_RESET;
        end else if (!ctrl.enable && !busy) begin
            pins <= PINS_RESET;
        end else begin
            pins.clk_oe <= 1'b1;
            pins.sel_oe <= 1'b1;
            case (state)
                ST_IDLE: begin
                    pins.clk_o <= ctrl.mode[1];
                    pins.data_oe <= 1'b0;
                    pins.sel_n_o <= 1'b1;
                    if (start) begin
                        // select goes active with the first data bit
                        pins.sel_n_o <= 1'b0;
                        pins.data_o <= wdata[ctrl.len_m1];
                        pins.data_oe <= ctrl.four_wire || !ctrl.rx_dir;
                    end
                end
                ST_SHIFT: begin
                    if (tick) begin
                        pins.clk_o <= ~pins.clk_o;
                        if (!sample_edge && !(cpha && edge_cnt == 5'h00)) begin
                            pins.data_o <= tx_sh[DATA_W-2];
                        end
                    end
                end
                ST_TRAIL: begin
                    if (tick) begin
                        // select released after the trailing half period
                        pins.sel_n_o <= 1'b1;
                        pins.data_oe <= 1'b0;
                        pins.clk_o <= cpol;
                    end
                end
                default: begin
                    pins.clk_o <= cpol;
                end
            endcase
        end
    end

    assign serial_clock_out = pins.clk_o;
    assign serial_clock_oe = pins.clk_oe;
    assign shared_data_line_o = pins.data_o;
    assign shared_data_line_oe = pins.data_oe;
    assign slave_select_out_n = pins.sel_n_o;
    assign slave_select_oe = pins.sel_oe;

    // sticky status; a new event wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            done <= 1'b0;
            refused <= 1'b0;
        end else begin
            if (state == ST_TRAIL && tick) begin
                done <= 1'b1;
            end else if (wr && addr == OFS_STATUS && wdata[STAT_DONE_BIT]) begin
                done <= 1'b0;
            end
            if (wr && addr == OFS_TXDATA && !start) begin
                refused <= 1'b1;
            end else if (wr && addr == OFS_STATUS && wdata[STAT_REFUSED_BIT]) begin
                refused <= 1'b0;
            end
        end
    end

    // read data, one cycle after the strobe and only then
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rdata <= RDATA_UNMAPPED;
        end else if (rd) begin
            case (addr)
                OFS_CTRL: begin
                    rdata <= 32'({ctrl.len_m1, 2'b00, ctrl.mode, 1'b0, ctrl.rx_dir,
                        ctrl.four_wire, ctrl.enable});
                end
                OFS_DIVIDER: rdata <= 32'(half);
                OFS_TXDATA: rdata <= 32'(tx_word);
                OFS_RXDATA: rdata <= 32'(rx_word);
                OFS_STATUS: rdata <= 32'({refused, done, busy});
                default: rdata <= RDATA_UNMAPPED;
            endcase
        end else begin
            rdata <= RDATA_UNMAPPED;
        end
    end

endmodule

/* tb/spi_slave_model.sv */
`timescale 1ns/10ps
module spi_slave_model (
    // serial side
    input wire logic sck,
    input wire logic sel_n,
    input wire logic sdi,
    output logic sdo,
    // word setup, reply left aligned
    input wire logic [1:0] mode,
    input wire logic [15:0] resp,
    output logic [15:0] got
);
    logic [15:0] sh;
    logic first;
    logic sel_q;
    // one process owns every model variable, so nothing has two drivers
    initial begin
        {got, sh, first, sdo} = 34'h0;
        sel_q = 1'b1;
        forever begin
            @(sck or sel_n);
            if (sel_n !== sel_q) begin
                // select opens a word; released line flips, never keeps its bit
                if (sel_n === 1'b0) begin
                    {got, sh, first, sdo} = {16'h0, resp, mode[0], resp[15]};
                end else begin
                    sdo = ~sdo;
                end
                sel_q = sel_n;
            end else if (sel_n === 1'b0) begin
                if (sck == !(mode[1] ^ mode[0])) begin
                    got = {got[14:0], sdi};
                end else if (first) begin
                    first = 1'b0;
                end else begin
                    {sh, sdo} = {sh[14:0], 1'b0, sh[14]};
                end
            end
        end
    end
endmodule

/* tb/serial_peripheral_master_chk.sv */
`timescale 1ns/10ps
module serial_peripheral_master_chk import spi_master_pkg::*; (
    // clock, reset, writes
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    // pins
    input wire logic serial_clock_out,
    input wire logic shared_data_line_o,
    input wire logic shared_data_line_oe,
    input wire logic slave_select_out_n,
    input wire logic slave_select_oe
);
    logic [11:0] ctl;
    logic [11:0] snap;
    logic [5:0] edges;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    always_ff @(posedge clk) begin
        if (!rst_b) ctl <= 12'h0;
        else if (wr && addr == OFS_CTRL) ctl <= wdata[11:0];
    end
    // control frozen for the running word
    always_ff @(posedge clk) begin
        if (!rst_b) snap <= 12'h0;
        else if ($fell(slave_select_out_n)) snap <= ctl;
    end
    always_ff @(posedge clk) begin
        if (!rst_b || slave_select_out_n) edges <= 6'h0;
        else if ($changed(serial_clock_out)) edges <= edges + 6'h1;
    end
    sequence s_sample_edge;
        !slave_select_out_n && shared_data_line_oe && $changed(serial_clock_out)
            && serial_clock_out == !(snap[5] ^ snap[4]);
    endsequence
    AST_SEL_START: assert property (wr && addr == OFS_TXDATA && slave_select_oe
        && slave_select_out_n && $past(slave_select_out_n) |=> !slave_select_out_n)
        else $error("no select");
    AST_SEL_DRIVEN: assert property (!slave_select_out_n |-> slave_select_oe)
        else $error("select floating");
    AST_HALF_MIN: assert property (
        $changed(serial_clock_out) && !slave_select_out_n |=> $stable(serial_clock_out) [*4])
        else $error("clock too fast");
    AST_EDGES: assert property (
        $rose(slave_select_out_n) |-> edges == (6'(snap[11:8]) + 6'h1) * 6'h2)
        else $error("edge count");
    AST_IDLE_LEVEL: assert property (
        $rose(slave_select_out_n) |-> serial_clock_out == snap[5]) else $error("idle level");
    AST_DRIVE: assert property (
        !slave_select_out_n && !$past(slave_select_out_n) && (snap[1] || !snap[2])
        |-> shared_data_line_oe) else $error("data not driven");
    AST_RELEASE: assert property (
        !slave_select_out_n && !$past(slave_select_out_n) && !snap[1] && snap[2]
        |-> !shared_data_line_oe) else $error("data not released");
    AST_SAMPLE_HOLD: assert property (
        s_sample_edge |-> $stable(shared_data_line_o) ##1 $stable(shared_data_line_o))
        else $error("data moved");
endmodule
bind serial_peripheral_master serial_peripheral_master_chk serial_peripheral_master_chk_i (
    .clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr),
    .serial_clock_out(serial_clock_out), .shared_data_line_o(shared_data_line_o),
    .shared_data_line_oe(shared_data_line_oe), .slave_select_out_n(slave_select_out_n),
    .slave_select_oe(slave_select_oe));

/* tb/test_serial_peripheral_master.sv */
`timescale 1ns/10ps
module test_serial_peripheral_master import spi_master_pkg::*; ();
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic rx3 = 1'b0;
    logic [7:0] addr = 8'h0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata, d;
    logic [1:0] m_mode = 2'h0;
    logic [15:0] m_resp = 16'h0, got;
    logic sck, sck_oe, sd_o, sd_oe, sel_n, sel_oe, sdo, sh_wire;
    int error_cnt = 0;
    int cmp_count = 0;
    always #4 clk = ~clk;
    // an undriven line shows the inverse of its last value, or the slave reply in a three-line read while selected
    assign sh_wire = sd_oe ? sd_o : ((rx3 && !sel_n) ? sdo : ~sd_o);
    serial_peripheral_master serial_peripheral_master_i (.clk(clk), .rst_b(rst_b), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .serial_clock_out(sck),
        .serial_clock_oe(sck_oe), .shared_data_line_i(sh_wire), .shared_data_line_o(sd_o),
        .shared_data_line_oe(sd_oe), .dedicated_data_in(rx3 ? ~sdo : sdo),
        .slave_select_out_n(sel_n), .slave_select_oe(sel_oe));
    spi_slave_model spi_slave_model_i (.sck(sck), .sel_n(sel_n), .sdi(sh_wire), .sdo(sdo),
        .mode(m_mode), .resp(m_resp), .got(got));
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic finish_test();
        $display("errors %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic regs_check();
        bus(1'b0, OFS_DIVIDER, 32'h0);
        check("divider", 32'(DIVIDER_RESET), d);
        check("pins", 32'h0, {30'h0, sck_oe, sel_oe});
        bus(1'b1, OFS_TXDATA, 32'h5);
        bus(1'b0, OFS_STATUS, 32'h0);
        check("refused", 32'h4, d);
        bus(1'b1, OFS_STATUS, 32'h4);
        bus(1'b0, 8'h20, 32'h0);
        check("unmapped", 32'h0, d);
        bus(1'b1, OFS_DIVIDER, 32'hffff);
        bus(1'b0, OFS_DIVIDER, 32'h0);
        check("divider max", 32'(HALF_MAX), d);
        // floor of the clamp gives the fastest clock
        bus(1'b1, OFS_DIVIDER, 32'h1);
        bus(1'b0, OFS_DIVIDER, 32'h0);
        check("divider min", 32'(HALF_MIN), d);
    endtask
    task automatic xfer(input logic [1:0] m, input logic [3:0] n1, input logic fw,
        input logic rx, input logic [15:0] tx, input logic [15:0] rsp);
        logic [15:0] mask;
        mask = 16'hffff >> (4'hf - n1);
        m_mode = m;
        m_resp = rsp << (4'hf - n1);
        rx3 = rx;
        bus(1'b1, OFS_CTRL, {20'h0, n1, 2'h0, m, 1'b0, rx, fw, 1'b1});
        bus(1'b0, OFS_CTRL, 32'h0);
        check("ctrl", {20'h0, n1, 2'h0, m, 1'b0, rx, fw, 1'b1}, d);
        bus(1'b1, OFS_TXDATA, {16'h0, tx});
        for (int i = 0; i < 400 && !d[STAT_DONE_BIT]; i++) bus(1'b0, OFS_STATUS, 32'h0);
        check("status", 32'h2, d);
        bus(1'b1, OFS_STATUS, 32'h2);
        bus(1'b0, OFS_RXDATA, 32'h0);
        if (fw || rx) check("rx word", {16'h0, rsp & mask}, d);
        if (!rx) check("tx word", {16'h0, tx & mask}, {16'h0, got & mask});
        bus(1'b0, OFS_TXDATA, 32'h0);
        check("tx reg", {16'h0, tx}, d);
    endtask
    task automatic busy_check();
        bus(1'b1, OFS_TXDATA, 32'h3);
        bus(1'b1, OFS_TXDATA, 32'h3);
        for (int i = 0; i < 400 && !d[STAT_DONE_BIT]; i++) bus(1'b0, OFS_STATUS, 32'h0);
        check("busy refused", 32'h6, d);
    endtask
    initial begin
        #200000;
        error_cnt++;
        finish_test();
    end
    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        regs_check();
        for (int m = 0; m < 4; m++) xfer(2'(m), 4'(m * 5), 1'b1, 1'b0, 16'hc3a5, 16'h5a3c);
        xfer(2'h1, 4'h7, 1'b0, 1'b0, 16'h00b6, 16'h0);
        xfer(2'h2, 4'hb, 1'b0, 1'b1, 16'h0, 16'h0e4d);
        busy_check();
        finish_test();
    end
endmodule
